// ===== npb_pkg.sv
// npb_pkg: page geometry, check-bit layout and shared types of the page core
package npb_pkg;
	// page geometry: 2048 main bytes then 64 spare bytes
	localparam int MAIN_BYTES = 2048;
	localparam int SPARE_BYTES = 64;
	localparam int PAGE_BYTES = MAIN_BYTES + SPARE_BYTES;
	localparam int PAGES_PER_BLOCK = 64;
	localparam int BLOCKS_PER_PLANE = 512;
	localparam int NUM_PLANES = 2;
	localparam int NUM_BLOCKS = BLOCKS_PER_PLANE * NUM_PLANES;
	localparam int COL_W = 12;
	localparam int ROW_W = 16;
	localparam int PAGE_BITS = 6;
	// row bit that picks the plane (lowest block-address bit)
	localparam int PLANE_BIT = PAGE_BITS;
	localparam logic [COL_W-1:0] PAGE_BYTES_C = 12'h840;
	localparam logic [COL_W-1:0] MAIN_BYTES_C = 12'h800;
	localparam logic [COL_W-1:0] COL_LAST = 12'h83f;
	localparam logic [COL_W-1:0] COL_ZERO = 12'h000;
	// check bits: four 512-byte sectors, two spare bytes each at the page end
	localparam int SECTORS = 4;
	localparam int SYN_W = 13;
	localparam int ECC_BASE = 2104;
	localparam logic [7:0] OOB_READ = 8'hff;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {OP_READ, OP_PROG, OP_ERASE, OP_COPY} npb_op_t;

	typedef enum {ST_IDLE, ST_RD_ARR, ST_RD_CPY, ST_PG_CPY, ST_PG_ECC,
		ST_PG_WR, ST_PG_CMT, ST_PG_WAIT, ST_ER_GO, ST_ER_WAIT} npb_state_t;

	typedef struct packed {
		npb_op_t op;
		logic [ROW_W-1:0] row;
		logic [ROW_W-1:0] dest;
	} npb_cmd_t;

	typedef struct packed {
		logic busy;
		logic ecc_fail;
		logic ecc_fixed;
		logic prog_fail;
		logic erase_fail;
	} npb_stat_t;

	typedef struct packed {
		logic en;
		logic we;
		logic commit;
		logic erase;
		logic plane_select_bit;
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
		logic [7:0] wdata;
	} npb_arr_t;

	// xor of (bit position + 1) over the set bits of one byte
	function automatic logic [SYN_W-1:0] byte_syn(input logic [8:0] bi,
		input logic [7:0] d);
		logic [SYN_W-1:0] acc;
		acc = '0;
		for (int b = 0; b < 8; b++) begin
			if (d[b]) begin
				acc = acc ^ ({1'b0, bi, 3'(b)} + 13'h0001);
			end
		end
		return acc;
	endfunction : byte_syn

	function automatic logic in_page(input logic [COL_W-1:0] col);
		return col < PAGE_BYTES_C;
	endfunction : in_page
endpackage : npb_pkg

// ===== npb_core.sv
// npb_core: cache and data page registers, check-bit engine, read fifo
// Function
// [R01] a page is 2112 bytes: 2048 main bytes then 64 spare bytes
// [R02] an erase block holds 64 individually programmable pages
// [R03] two planes of 512 blocks, 1024 blocks addressed by the row
// [R04] internal correction is switched on or off by the user
// [R05] with correction on, programming stores generated check bits in spare
// [R06] with correction on, a page read rechecks and corrects the page
// [R07] a corrected read gives fixed data or an uncorrectable flag
// [R08] pages move whole through a data register and a cache register
// [R09] read and program act on one page, erase on a whole block
// [R10] the host reads and loads any byte position of the cache
// [R11] page read, program, random access and copy-back are supported
// [R12] a status word reports progress and outcome of operations
// [R13] only columns 0 to 2111 exist; higher ones are never addressed
// [R14] one row bit selects the plane an operation targets
// [R15] with correction off data passes unchanged and no ecc flag sets

////////////////////////////////////////////////////////////////////////////
module npb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_q;
	logic [AW-1:0] rptr_q;
	logic [AW:0] count_q;
	logic [AW:0] count_d;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// flags are registered so the ready and valid ports come from flops
	assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data = mem[rptr_q];

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else if (ce) begin
			wptr_q <= push ? AW'(wptr_q + 1'b1) : wptr_q;
			rptr_q <= pop ? AW'(rptr_q + 1'b1) : rptr_q;
			count_q <= count_d;
			in_ready <= count_d < (AW+1)'(DEPTH);
			out_valid <= count_d != '0;
		end
	end

	// storage needs no reset; only pointers qualify it
	always_ff @(posedge clock) begin
		if (ce && push) begin
			mem[wptr_q] <= in_data;
		end
	end
endmodule : npb_fifo

////////////////////////////////////////////////////////////////////////////
module npb_core (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic ecc_en,
	input wire logic cmd_valid,
	input wire npb_pkg::npb_cmd_t cmd,
	output logic cmd_ready,
	input wire logic ld_valid,
	input wire logic [11:0] ld_col,
	input wire logic [7:0] ld_data,
	input wire logic rd_valid,
	input wire logic [11:0] rd_col,
	output logic rd_ready,
	output logic out_valid,
	input wire logic out_ready,
	output logic [7:0] out_data,
	output npb_pkg::npb_arr_t arr,
	input wire logic [7:0] arr_rdata,
	input wire logic arr_done,
	input wire logic arr_fail,
	output npb_pkg::npb_stat_t stat
);
	// the two page registers, one byte per column
	logic [7:0] cache_q [npb_pkg::PAGE_BYTES]; // R01
	logic [7:0] dreg_q [npb_pkg::PAGE_BYTES];

	npb_pkg::npb_state_t state_q;
	npb_pkg::npb_state_t state_d;
	npb_pkg::npb_op_t op_q;
	npb_pkg::npb_arr_t arr_d;
	npb_pkg::npb_stat_t stat_d;
	logic [15:0] row_q;
	logic [15:0] dest_q;
	logic [11:0] idx_q;
	logic [11:0] idx_d;
	logic [11:0] c1_q;
	logic v1_q;
	logic ecc_on_q;
	logic [12:0] syn_q [npb_pkg::SECTORS];
	logic par_q [npb_pkg::SECTORS];
	logic [12:0] pos [npb_pkg::SECTORS];
	logic [3:0] sec_fix;
	logic [3:0] sec_bad;

	////////////////////////////////////////////////////////////////////////
	// request decode
	wire cmd_take = cmd_valid && cmd_ready;
	wire ld_take = ld_valid && cmd_ready && npb_pkg::in_page(ld_col); // R13
	wire rd_push = rd_valid && cmd_ready;
	wire [7:0] rd_byte = npb_pkg::in_page(rd_col) ? cache_q[rd_col] :
		npb_pkg::OOB_READ; // R13
	wire idx_last = idx_q == npb_pkg::COL_LAST;
	wire [11:0] idx_inc = idx_q + 12'h001;
	wire rd_cpy_last = state_q == npb_pkg::ST_RD_CPY && idx_last;
	wire pg_cpy_last = state_q == npb_pkg::ST_PG_CPY && idx_last;
	wire cap_last = v1_q && c1_q == npb_pkg::COL_LAST;
	wire is_copy = op_q == npb_pkg::OP_COPY;
	wire prog_op = cmd.op == npb_pkg::OP_PROG || cmd.op == npb_pkg::OP_COPY;

	// check-bit accumulation source: array capture on reads, cache on programs
	wire pg_cpy = state_q == npb_pkg::ST_PG_CPY;
	wire [11:0] acc_col = pg_cpy ? idx_q : c1_q;
	wire [7:0] acc_byte = pg_cpy ? cache_q[idx_q] : arr_rdata;
	wire acc_en = ecc_on_q && (pg_cpy || v1_q) &&
		acc_col < npb_pkg::MAIN_BYTES_C; // R05 R06 R15
	wire [1:0] acc_sec = acc_col[10:9];
	wire [12:0] acc_syn = npb_pkg::byte_syn(acc_col[8:0], acc_byte);
	wire syn_clr = cmd_take || rd_cpy_last;

	////////////////////////////////////////////////////////////////////////
	// per-sector compare of recomputed against stored check bits
	// one flipped bit per 512-byte sector is fixed, so up to four per page;
	// a double error inside one sector is flagged rather than miscorrected
	for (genvar s = 0; s < npb_pkg::SECTORS; s++) begin : g_sec
		wire [15:0] stored = {dreg_q[npb_pkg::ECC_BASE + 2*s],
			dreg_q[npb_pkg::ECC_BASE + 2*s + 1]};
		wire [12:0] dsyn = syn_q[s] ^ stored[12:0];
		wire dpar = par_q[s] ^ stored[15];
		assign pos[s] = dsyn - 13'h0001;
		assign sec_fix[s] = dpar && dsyn != '0 && !pos[s][12]; // R06
		assign sec_bad[s] = dsyn != '0 && (!dpar || pos[s][12]); // R07
	end

	// flip mask for the byte now copied from data to cache register
	wire [1:0] fix_sec = idx_q[10:9];
	wire fix_hit = ecc_on_q && idx_q < npb_pkg::MAIN_BYTES_C &&
		sec_fix[fix_sec] && pos[fix_sec][11:3] == idx_q[8:0]; // R06 R15
	wire [7:0] fix_mask = fix_hit ? (8'h01 << pos[fix_sec][2:0]) : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// sequencer: one byte per cycle over the whole page
	always_comb begin
		state_d = state_q;
		idx_d = idx_q;
		arr_d = '0;
		arr_d.row = row_q;
		arr_d.plane_select_bit = row_q[npb_pkg::PLANE_BIT]; // R14
		unique case (state_q)
			npb_pkg::ST_IDLE: begin
				idx_d = npb_pkg::COL_ZERO;
				if (cmd_take) begin
					unique case (cmd.op)
						npb_pkg::OP_ERASE: state_d = npb_pkg::ST_ER_GO;
						npb_pkg::OP_PROG: state_d = npb_pkg::ST_PG_CPY;
						npb_pkg::OP_READ: state_d = npb_pkg::ST_RD_ARR;
						npb_pkg::OP_COPY: state_d = npb_pkg::ST_RD_ARR; // R11
					endcase
				end
			end
			npb_pkg::ST_RD_ARR: begin
				if (npb_pkg::in_page(idx_q)) begin
					arr_d.en = 1'b1; // R08 R13
					arr_d.col = idx_q;
					idx_d = idx_inc;
				end
				if (cap_last) begin
					state_d = npb_pkg::ST_RD_CPY;
					idx_d = npb_pkg::COL_ZERO;
				end
			end
			npb_pkg::ST_RD_CPY: begin
				idx_d = idx_last ? npb_pkg::COL_ZERO : idx_inc;
				if (idx_last) begin
					state_d = is_copy ? npb_pkg::ST_PG_CPY : npb_pkg::ST_IDLE;
				end
			end
			npb_pkg::ST_PG_CPY: begin
				idx_d = idx_last ? npb_pkg::COL_ZERO : idx_inc;
				if (idx_last) begin
					state_d = ecc_on_q ? npb_pkg::ST_PG_ECC :
						npb_pkg::ST_PG_WR; // R05 R15
				end
			end
			npb_pkg::ST_PG_ECC: state_d = npb_pkg::ST_PG_WR;
			npb_pkg::ST_PG_WR: begin
				arr_d.en = 1'b1; // R08 R09
				arr_d.we = 1'b1;
				arr_d.col = idx_q;
				arr_d.wdata = dreg_q[idx_q];
				idx_d = idx_inc;
				if (idx_last) begin
					state_d = npb_pkg::ST_PG_CMT;
				end
			end
			npb_pkg::ST_PG_CMT: begin
				arr_d.commit = 1'b1;
				state_d = npb_pkg::ST_PG_WAIT;
			end
			npb_pkg::ST_PG_WAIT: begin
				if (arr_done) begin
					state_d = npb_pkg::ST_IDLE;
				end
			end
			npb_pkg::ST_ER_GO: begin
				// the page bits are cleared so the whole block is named
				arr_d.erase = 1'b1; // R09 R02 R03
				arr_d.row = {row_q[15:npb_pkg::PAGE_BITS], 6'h00};
				state_d = npb_pkg::ST_ER_WAIT;
			end
			npb_pkg::ST_ER_WAIT: begin
				if (arr_done) begin
					state_d = npb_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// status next value; fail flags clear when their kind restarts, ecc flags are rewritten at the end of each read copy
	always_comb begin
		stat_d = stat;
		stat_d.busy = state_d != npb_pkg::ST_IDLE; // R12
		if (cmd_take && prog_op) begin
			stat_d.prog_fail = 1'b0;
		end
		if (cmd_take && cmd.op == npb_pkg::OP_ERASE) begin
			stat_d.erase_fail = 1'b0;
		end
		if (rd_cpy_last) begin
			stat_d.ecc_fail = ecc_on_q && |sec_bad; // R07 R15
			stat_d.ecc_fixed = ecc_on_q && |sec_fix; // R07 R15
		end
		if (state_q == npb_pkg::ST_PG_WAIT && arr_done) begin
			stat_d.prog_fail = arr_fail; // R12
		end
		if (state_q == npb_pkg::ST_ER_WAIT && arr_done) begin
			stat_d.erase_fail = arr_fail; // R12
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control flops
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= npb_pkg::ST_IDLE;
			idx_q <= '0;
			arr <= '0;
			stat <= '0;
			cmd_ready <= 1'b1;
			v1_q <= 1'b0;
			c1_q <= '0;
		end else if (ce) begin
			state_q <= state_d;
			idx_q <= idx_d;
			arr <= arr_d;
			stat <= stat_d;
			cmd_ready <= state_d == npb_pkg::ST_IDLE;
			v1_q <= arr.en && !arr.we; // read data returns one cycle later
			c1_q <= arr.col;
		end
	end

	// operation context latched at command accept
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			op_q <= npb_pkg::OP_READ;
			row_q <= '0;
			dest_q <= '0;
			ecc_on_q <= 1'b0;
		end else if (ce && cmd_take) begin
			op_q <= cmd.op;
			row_q <= cmd.row;
			dest_q <= cmd.dest;
			ecc_on_q <= ecc_en; // R04
		end else if (ce && rd_cpy_last && is_copy) begin
			row_q <= dest_q; // R11
		end
	end

	// running check bits per sector
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			for (int s = 0; s < npb_pkg::SECTORS; s++) begin
				syn_q[s] <= '0;
				par_q[s] <= 1'b0;
			end
		end else if (ce) begin
			for (int s = 0; s < npb_pkg::SECTORS; s++) begin
				if (syn_clr) begin
					syn_q[s] <= '0;
					par_q[s] <= 1'b0;
				end else if (acc_en && acc_sec == 2'(s)) begin
					syn_q[s] <= syn_q[s] ^ acc_syn; // R05 R06
					par_q[s] <= par_q[s] ^ (^acc_byte);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// cache register: host loads while idle, corrected copy on reads
	always_ff @(posedge clock) begin
		if (ce && ld_take) begin
			cache_q[ld_col] <= ld_data; // R10
		end
		if (ce && state_q == npb_pkg::ST_RD_CPY) begin
			cache_q[idx_q] <= dreg_q[idx_q] ^ fix_mask; // R06 R08
		end
	end

	// data register: array capture, cache copy, check-bit insertion
	always_ff @(posedge clock) begin
		if (ce && v1_q) begin
			dreg_q[c1_q] <= arr_rdata; // R08
		end
		if (ce && pg_cpy) begin
			dreg_q[idx_q] <= cache_q[idx_q]; // R08
		end
		if (ce && state_q == npb_pkg::ST_PG_ECC) begin
			for (int s = 0; s < npb_pkg::SECTORS; s++) begin
				dreg_q[npb_pkg::ECC_BASE + 2*s] <=
					{par_q[s], 2'b00, syn_q[s][12:8]}; // R05
				dreg_q[npb_pkg::ECC_BASE + 2*s + 1] <= syn_q[s][7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// host read stream; a full fifo stalls the host through rd_ready
	npb_fifo #(
		.WIDTH(8),
		.DEPTH(npb_pkg::FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.sys_rst(sys_rst),
		.ce(ce),
		.in_valid(rd_push),
		.in_ready(rd_ready),
		.in_data(rd_byte), // R10
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst || !ce);

	sequence s_prog_tail;
		state_q == npb_pkg::ST_PG_ECC ##1 state_q == npb_pkg::ST_PG_WR;
	endsequence
	sequence s_commit_wait;
		state_q == npb_pkg::ST_PG_CMT ##1 state_q == npb_pkg::ST_PG_WAIT;
	endsequence

	a_col_bound: assert property (arr.en |-> // R13
		arr.col < npb_pkg::PAGE_BYTES_C)
		else $error("array column out of page");
	a_plane_pick: assert property ((arr.en || arr.erase || // R14
		arr.commit) |-> arr.plane_select_bit == arr.row[npb_pkg::PLANE_BIT])
		else $error("plane select disagrees with row");
	a_erase_block: assert property (arr.erase |-> arr.row[5:0] == 6'h00) // R09
		else $error("erase row names a page");
	a_prog_ecc: assert property (pg_cpy_last && ecc_on_q |=> // R05
		s_prog_tail)
		else $error("check bits not inserted before write");
	a_prog_plain: assert property (pg_cpy_last && !ecc_on_q |=> // R15
		state_q == npb_pkg::ST_PG_WR)
		else $error("check bits written with correction off");
	// the commit pulse stands in the same cycle the wait state begins
	a_commit_seq: assert property (state_q == npb_pkg::ST_PG_WR && // R09
		idx_last |=> s_commit_wait ##0 (arr.commit &&
		$past(arr.col) == npb_pkg::COL_LAST))
		else $error("commit not after last page byte");
	a_ecc_flag: assert property (rd_cpy_last |=> stat.ecc_fail == // R07
		$past(ecc_on_q && |sec_bad) && stat.ecc_fixed ==
		$past(ecc_on_q && |sec_fix))
		else $error("correction status wrong after read");
	a_ecc_off: assert property (rd_cpy_last && !ecc_on_q |=> // R15
		!stat.ecc_fail && !stat.ecc_fixed)
		else $error("ecc flag set with correction off");
	a_copy_chain: assert property (rd_cpy_last && is_copy |=> // R11
		state_q == npb_pkg::ST_PG_CPY && row_q == $past(dest_q))
		else $error("copy-back did not continue to program");
	a_busy_stat: assert property (stat.busy == !cmd_ready) // R12
		else $error("busy and ready disagree");
	a_out_hold: assert property (out_valid && !out_ready |=> // R10
		out_valid && $stable(out_data))
		else $error("read byte dropped while stalled");
endmodule : npb_core

// ===== npb_arr_model.sv
// npb_arr_model: behavioural page array behind the core's array port
module npb_arr_model (
	input wire logic clock,
	input wire logic sys_rst,
	input wire npb_pkg::npb_arr_t arr,
	output logic [7:0] arr_rdata,
	output logic arr_done,
	output logic arr_fail
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [logic [27:0]];
	logic fail_next = 1'b0;
	logic slow = 1'b0;
	int plane_err = 0;
	int wait_q = 0;
	logic pend_q = 1'b0;

	// flip one stored bit, as a worn cell would
	task automatic flip(input logic [15:0] row, input logic [11:0] col,
		input int b);
		logic [7:0] v;
		v = mem.exists({row, col}) ? mem[{row, col}] : 8'hff;
		v[b] = ~v[b];
		mem[{row, col}] = v;
	endtask : flip

	////////////////////////////////////////////////////////////////////////
	// reads answer next cycle; an idle data bus toggles so stale data shows
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			arr_rdata <= 8'h00;
			arr_done <= 1'b0;
			arr_fail <= 1'b0;
			pend_q <= 1'b0;
		end else begin
			arr_done <= 1'b0;
			arr_fail <= 1'b0;
			arr_rdata <= ~arr_rdata;
			if ((arr.en | arr.erase | arr.commit) &&
				arr.plane_select_bit !== arr.row[6]) begin
				plane_err++;
			end
			if (arr.en && (arr.col >= 12'h840)) begin
				plane_err++;
			end
			if (arr.en && !arr.we) begin
				arr_rdata <= mem.exists({arr.row, arr.col}) ?
					mem[{arr.row, arr.col}] : 8'hff;
			end
			// programming can only clear bits, never set them back
			if (arr.en && arr.we) begin
				mem[{arr.row, arr.col}] = arr.wdata &
					(mem.exists({arr.row, arr.col}) ?
					mem[{arr.row, arr.col}] : 8'hff);
			end
			if (arr.erase) begin
				for (int p = 0; p < 64; p++) begin
					for (int c = 0; c < 2112; c++) begin
						mem.delete({arr.row[15:6], 6'(p), 12'(c)});
					end
				end
			end
			if (arr.commit | arr.erase) begin
				pend_q <= 1'b1;
				wait_q <= slow ? 40 : 3;
			end else if (pend_q && wait_q == 0) begin
				pend_q <= 1'b0;
				arr_done <= 1'b1;
				arr_fail <= fail_next;
			end else if (pend_q) begin
				wait_q <= wait_q - 1;
			end
		end
	end
endmodule : npb_arr_model

// ===== tb_top.sv
// tb_top: self-checking bench for the page buffer core
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] ROW_A = 16'h0143;
	localparam logic [15:0] ROW_B = 16'h0201;
	localparam logic [15:0] ROW_C = 16'h0247;
	localparam logic [15:0] ROW_D = 16'h0300;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic ecc_en = 1'b0;
	logic cmd_valid = 1'b0;
	npb_pkg::npb_cmd_t cmd = '0;
	logic ld_valid = 1'b0;
	logic [11:0] ld_col = 12'h000;
	logic [7:0] ld_data = 8'h00;
	logic rd_valid = 1'b0;
	logic [11:0] rd_col = 12'h000;
	logic out_ready = 1'b0;
	logic cmd_ready, rd_ready, out_valid, arr_done, arr_fail;
	logic [7:0] out_data, arr_rdata;
	npb_pkg::npb_arr_t arr;
	npb_pkg::npb_stat_t stat;
	logic [7:0] page [0:2111];
	logic [7:0] expq [$];
	logic [7:0] exp_b;
	logic [15:0] rnd = 16'hfe65;
	logic [15:0] ord = 16'hfe65;
	int miscompares = 0;
	int n_tests = 0;

	always #5 clock = ~clock;

	npb_core npb_core_inst (.clock(clock), .sys_rst(sys_rst), .ce(1'b1),
		.ecc_en(ecc_en), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_ready(cmd_ready), .ld_valid(ld_valid), .ld_col(ld_col),
		.ld_data(ld_data), .rd_valid(rd_valid), .rd_col(rd_col),
		.rd_ready(rd_ready), .out_valid(out_valid), .out_ready(out_ready),
		.out_data(out_data), .arr(arr), .arr_rdata(arr_rdata),
		.arr_done(arr_done), .arr_fail(arr_fail), .stat(stat));
	npb_arr_model npb_arr_model_inst (.clock(clock), .sys_rst(sys_rst),
		.arr(arr), .arr_rdata(arr_rdata), .arr_done(arr_done),
		.arr_fail(arr_fail));

	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic complete_run();
		if (miscompares == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : complete_run

	task automatic tick();
		@(posedge clock);
		#1;
	endtask : tick

	////////////////////////////////////////////////////////////////////////
	// host side drains at a random pace so the fifo fills and stalls;
	// the head is checked mid-cycle, settled, before the edge that pops it
	always @(negedge clock) begin
		if (!sys_rst && out_valid === 1'b1 && out_ready === 1'b1) begin
			exp_b = expq.size() ? expq.pop_front() : 8'hxx;
			chk("read byte", exp_b, out_data);
		end
	end

	// drain pace changes just after each rising edge
	always @(posedge clock) begin
		#1;
		ord = lfsr(ord);
		out_ready = ord[0] | ord[1];
	end

	// a command is held until taken, then waited for under a bound
	task automatic run(input npb_pkg::npb_op_t op, input logic [15:0] row,
		input logic [15:0] dest, input logic ecc);
		int n;
		n = 0;
		ecc_en = ecc;
		cmd = '{op: op, row: row, dest: dest};
		cmd_valid = 1'b1;
		do @(posedge clock); while (cmd_ready !== 1'b1);
		#1;
		cmd_valid = 1'b0;
		tick();
		tick();
		chk("busy", 8'h02, {6'h00, stat.busy, cmd_ready});
		while (cmd_ready !== 1'b1 && n < 20000) begin
			tick();
			n++;
		end
		chk("op end", 8'h01, {7'h00, cmd_ready});
	endtask : run

	task automatic load_page();
		ld_valid = 1'b1;
		for (int c = 0; c < 2113; c++) begin
			rnd = lfsr(rnd);
			ld_col = 12'(c);
			ld_data = rnd[7:0];
			if (c < 2112) page[c] = rnd[7:0];
			tick();
		end
		ld_valid = 1'b0;
	endtask : load_page

	task automatic rd(input logic [11:0] col, input logic [7:0] exp);
		int n;
		n = 0;
		rd_col = col;
		rd_valid = 1'b1;
		do begin
			@(posedge clock);
			n++;
		end while (!(rd_ready === 1'b1 && cmd_ready === 1'b1) && n < 1000);
		expq.push_back(exp);
		#1;
	endtask : rd

	task automatic drain();
		int n;
		n = 0;
		rd_valid = 1'b0;
		tick();
		while (expq.size() != 0 && n < 10000) begin
			tick();
			n++;
		end
		chk("fifo drained", 8'h00, 8'(expq.size()));
	endtask : drain

	task automatic rd_page(input int last);
		for (int c = 0; c <= last; c++) rd(12'(c), page[c]);
		drain();
	endtask : rd_page

	task automatic rd_erased();
		for (int i = 0; i < 24; i++) begin
			rnd = lfsr(rnd);
			rd(rnd[11:0], 8'hff);
		end
		drain();
	endtask : rd_erased

	// one worn bit in each sector; the bench copy tracks the raw page
	task automatic wear(input int s);
		for (int i = 0; i < 4; i++) begin
			npb_arr_model_inst.flip(ROW_B, 12'(17 + 512 * i), i * 2);
			page[17 + 512 * i][i * 2] ^= s[0];
		end
	endtask : wear

	initial begin
		repeat (3) @(posedge clock);
		#1;
		sys_rst = 1'b0;
		chk("reset ready", 8'h03, {6'h00, cmd_ready, rd_ready});
		chk("reset stat", 8'h00, {3'h0, stat});
		load_page();
		rd(12'h840, 8'hff);
		rd(12'h83f, page[2111]);
		drain();
		run(npb_pkg::OP_PROG, ROW_A, 16'h0000, 1'b0);
		run(npb_pkg::OP_READ, ROW_A, 16'h0000, 1'b0);
		rd_page(2111);
		run(npb_pkg::OP_PROG, ROW_B, 16'h0000, 1'b1);
		wear(1);
		run(npb_pkg::OP_READ, ROW_B, 16'h0000, 1'b0);
		chk("plain stat", 8'h00, {3'h0, stat});
		rd_page(2103);
		// the array keeps its worn bits; only the bench copy is restored
		for (int i = 0; i < 4; i++) page[17 + 512 * i][i * 2] ^= 1'b1;
		run(npb_pkg::OP_READ, ROW_B, 16'h0000, 1'b1);
		chk("fixed stat", 8'h04, {3'h0, stat});
		rd_page(2103);
		npb_arr_model_inst.flip(ROW_B, 12'h259, 5);
		run(npb_pkg::OP_READ, ROW_B, 16'h0000, 1'b1);
		chk("ecc fail", 8'h01, {7'h00, stat.ecc_fail});
		run(npb_pkg::OP_ERASE, ROW_B, 16'h0000, 1'b0);
		run(npb_pkg::OP_READ, ROW_B, 16'h0000, 1'b0);
		rd_erased();
		run(npb_pkg::OP_COPY, ROW_A, ROW_C, 1'b0);
		run(npb_pkg::OP_READ, ROW_C, 16'h0000, 1'b0);
		rd_page(2111);
		npb_arr_model_inst.slow = 1'b1;
		npb_arr_model_inst.fail_next = 1'b1;
		run(npb_pkg::OP_PROG, ROW_D, 16'h0000, 1'b1);
		chk("prog fail", 8'h01, {7'h00, stat.prog_fail});
		run(npb_pkg::OP_ERASE, ROW_D, 16'h0000, 1'b0);
		chk("erase fail", 8'h01, {7'h00, stat.erase_fail});
		npb_arr_model_inst.fail_next = 1'b0;
		run(npb_pkg::OP_ERASE, ROW_D, 16'h0000, 1'b0);
		chk("erase ok", 8'h00, {7'h00, stat.erase_fail});
		chk("plane bit", 8'h00, 8'(npb_arr_model_inst.plane_err));
		complete_run();
	end

	// watchdog: about one and a half times the expected run length
	initial begin
		#900000;
		miscompares++;
		complete_run();
	end
endmodule : tb_top
